// *** verif/adc_host_model.sv ***
// host-side model driving the shared control pins and serial frames
`timescale 1ns/1ps
module adc_host_model (
    input wire logic go_in,
    input wire logic [19:0] frame_in,
    input wire logic swing_in,
    input wire logic edge_in,
    input wire logic delay_in,
    output logic sclk_out,
    output logic serial_input_line_out,
    output logic cs_n_out,
    output logic busy_out
);
    // ========================================
    // frame engine on its own 30 ns link clock
    logic sclk;
    logic serial_input_line;
    logic cs_n;
    initial begin
        busy_out = 1'b0;
        sclk = 1'b0;
        serial_input_line = 1'b0;
        cs_n = 1'b1;
    end
    // link clock stands still low outside frames
    always @(posedge go_in) begin
        busy_out = 1'b1;
        cs_n = 1'b0;
        #7;
        for (int i = 19; i >= 0; i--) begin
            serial_input_line = frame_in[i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        #15 cs_n = 1'b1;
        serial_input_line = ~serial_input_line;
        busy_out = 1'b0;
    end
    // static strap levels between frames
    assign sclk_out = busy_out ? sclk : swing_in;
    assign serial_input_line_out = busy_out ? serial_input_line : edge_in;
    assign cs_n_out = busy_out ? cs_n : delay_in;
endmodule : adc_host_model

// *** verif/test_adc_control_pin_mode_logic.sv ***
// self-checking bench for the control pin and mode logic
`timescale 1ns/1ps
module test_adc_control_pin_mode_logic;
    logic clk_in = 0, rst_in, go = 0, swing = 1, edge_hi = 0;
    logic edge_mid = 0, dly = 1, pd = 0, cal = 1, rs_s = 0, rs_d = 0;
    logic wr = 0, rd = 0, sclk, serial_input_line, cs_n, busy;
    logic [19:0] frame = '0;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [15:0] rdata;
    logic ext, full_scale_range_select, sw, ddr, oedge, pdo, flag, output_data_clock, lvalid;
    logic [3:0][7:0] lanes;
    adc_ctrl_pkg::tri_pin_t range_pin = '0;
    adc_ctrl_pkg::tri_pin_t edge_pin;
    adc_ctrl_pkg::sample_pair_t smp = '0;
    int miscompares = 0, total_checks = 0, cycles = 0;
    logic seen;
    assign edge_pin = {edge_mid, serial_input_line};
    always #50 clk_in = ~clk_in;
    adc_host_model host (.go_in(go), .frame_in(frame), .swing_in(swing),
        .edge_in(edge_hi), .delay_in(dly), .sclk_out(sclk),
        .serial_input_line_out(serial_input_line), .cs_n_out(cs_n), .busy_out(busy));
    adc_ctrl #(.CAL_DELAY_SHORT(4), .CAL_DELAY_LONG(8), .CAL_RUN(16)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .serial_clock_in(sclk),
        .range_pin_in(range_pin), .edge_pin_in(edge_pin),
        .delay_pin_in(cs_n), .power_down_pin_in(pd), .cal_pin_in(cal),
        .sync_reset_single_in(rs_s), .sync_reset_diff_in(rs_d),
        .sample_in(smp), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .extended_mode_out(ext), .full_scale_range_out(full_scale_range_select),
        .output_swing_out(sw), .ddr_mode_out(ddr),
        .output_edge_out(oedge), .power_down_out(pdo),
        .calibration_running_flag_out(flag),
        .output_data_clock_out(output_data_clock), .lane_data_out(lanes),
        .lane_valid_out(lvalid));
    // ========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : reg_rd
    // low phase, then high phase while watching the running flag
    task automatic cal_seq(input int lo, input int hi, input logic exp);
        @(posedge clk_in);
        cal <= 1'b0;
        cyc(lo);
        cal <= 1'b1;
        seen = 1'b0;
        repeat (hi) begin
            @(posedge clk_in);
            if (flag === 1'b1) seen = 1'b1;
        end
        check(seen, exp);
        cyc(24);
    endtask : cal_seq
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ========================================
    // main sequence
    initial begin
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        check(sw, 1'b1);
        reg_rd(4'h1, 16'h0002);
        reg_rd(4'h5, 16'h0000);
        cyc(40);
        range_pin <= '{mid: 1'b0, high: 1'b1};
        swing <= 1'b0;
        edge_mid <= 1'b1;
        cyc(6);
        check({full_scale_range_select, sw, ddr, ext}, 4'b1010);
        range_pin <= '0;
        swing <= 1'b1;
        edge_mid <= 1'b0;
        edge_hi <= 1'b1;
        cyc(6);
        check({full_scale_range_select, sw, ddr, oedge}, 4'b0101);
        cal_seq(90, 90, 1'b1);
        cal_seq(40, 90, 1'b0);
        pd <= 1'b1;
        cyc(6);
        check(pdo, 1'b1);
        pd <= 1'b0;
        seen = 1'b0;
        repeat (60) begin
            @(posedge clk_in);
            if (flag === 1'b1) seen = 1'b1;
        end
        check(seen, 1'b1);
        smp <= '{rise: 8'h05, fall: 8'hF0};
        reg_wr(4'h1, 16'h4002);
        reg_rd(4'h1, 16'h4002);
        rs_d <= 1'b1;
        cyc(4);
        rs_d <= 1'b0;
        cyc(8);
        check(lvalid | output_data_clock, 1'b1);
        repeat (4) if (lvalid !== 1'b1) @(posedge clk_in);
        check(lanes, 32'h70857085);
        rs_s <= 1'b1;
        cyc(3);
        rs_s <= 1'b0;
        swing <= 1'b0;
        range_pin <= '{mid: 1'b1, high: 1'b1};
        cyc(6);
        check(ext, 1'b1);
        frame <= {4'h1, 16'h4009};
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        repeat (40) if (busy === 1'b1) @(posedge clk_in);
        cyc(8);
        reg_rd(4'h1, 16'h4009);
        reg_rd(4'h2, 16'h4009);
        check({full_scale_range_select, sw, ddr}, 3'b101);
        pd <= 1'b1;
        cyc(4);
        pd <= 1'b0;
        cyc(8);
        check(flag, 1'b1);
        print_verdict();
    end
endmodule : test_adc_control_pin_mode_logic

// *** verilog/adc_ctrl.sv ***
// control pin decoding, calibration start, serial port and output demux
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module adc_ctrl #(
    parameter int CAL_DELAY_SHORT = adc_ctrl_pkg::CAL_DELAY_SHORT_CYCLES,
    parameter int CAL_DELAY_LONG = adc_ctrl_pkg::CAL_DELAY_LONG_CYCLES,
    parameter int CAL_RUN = adc_ctrl_pkg::CAL_RUN_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_clock_in,
    input wire adc_ctrl_pkg::tri_pin_t range_pin_in,
    input wire adc_ctrl_pkg::tri_pin_t edge_pin_in,
    input wire logic delay_pin_in,
    input wire logic power_down_pin_in,
    input wire logic cal_pin_in,
    input wire logic sync_reset_single_in,
    input wire logic sync_reset_diff_in,
    input wire adc_ctrl_pkg::sample_pair_t sample_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    output logic extended_mode_out,
    output logic full_scale_range_out,
    output logic output_swing_out,
    output logic ddr_mode_out,
    output logic output_edge_out,
    output logic power_down_out,
    output logic calibration_running_flag_out,
    output logic output_data_clock_out,
    output logic [3:0][7:0] lane_data_out,
    output logic lane_valid_out
);

    // ========================================
    // parameter checks
    if (CAL_DELAY_SHORT < 1 ||
        CAL_DELAY_LONG < CAL_DELAY_SHORT) begin : g_chk_dly
        $error("calibration delays must be positive and ordered");
    end
    if (CAL_RUN < 1) begin : g_chk_run
        $error("calibration run length must be positive");
    end

    // ========================================
    // link domain: serial shift register
    logic [4:0] ser_count;
    logic [19:0] ser_shift;
    adc_ctrl_pkg::serial_word_t ser_word;
    logic ser_toggle;
    wire logic [19:0] ser_next_shift =
        {ser_shift[18:0], edge_pin_in.high};
    wire logic ser_last = (ser_count == 5'(adc_ctrl_pkg::SER_FRAME_BITS - 1));

    // chip select high ends a frame even though the serial clock stops
    always_ff @(posedge serial_clock_in or posedge delay_pin_in) begin
        if (delay_pin_in) begin
            ser_count <= 5'h00;
        end else begin
            ser_count <= ser_last ? 5'h00 : ser_count + 5'h01;
        end
    end

    always_ff @(posedge serial_clock_in) begin
        if (!delay_pin_in) begin
            ser_shift <= ser_next_shift;
        end
    end

    // word stands until the next full frame; frames are far slower
    // than the three-cycle crossing below
    always_ff @(posedge serial_clock_in) begin
        if (!delay_pin_in && ser_last) begin
            ser_word <= adc_ctrl_pkg::serial_word_t'(ser_next_shift);
        end
    end

    // block reset clears the toggle while the serial clock stands still,
    // so both ends of the crossing start level
    always_ff @(posedge serial_clock_in or posedge rst_in) begin
        if (rst_in) begin
            ser_toggle <= 1'b0;
        end else if (!delay_pin_in && ser_last) begin
            ser_toggle <= ~ser_toggle;
        end
    end

    // ========================================
    // input synchronisers
    adc_ctrl_pkg::tri_pin_t range_meta, range_sync, edge_meta, edge_sync;
    logic [7:0] lvl_meta, lvl_sync;
    logic ser_tog_sync, ser_tog_seen;
    wire logic [7:0] lvl_raw = {ser_toggle, sync_reset_diff_in,
        sync_reset_single_in, cal_pin_in, power_down_pin_in, delay_pin_in,
        serial_clock_in, 1'b0};

    always_ff @(posedge clk_in) begin
        range_meta <= range_pin_in;
        range_sync <= range_meta;
        edge_meta <= edge_pin_in;
        edge_sync <= edge_meta;
        lvl_meta <= lvl_raw;
        lvl_sync <= lvl_meta;
    end

    wire logic swing_sync = lvl_sync[1];
    wire logic delay_sync = lvl_sync[2];
    wire logic pd_sync = lvl_sync[3];
    wire logic cal_sync = lvl_sync[4];
    wire logic rst_single_sync = lvl_sync[5];
    wire logic rst_diff_sync = lvl_sync[6];
    assign ser_tog_sync = lvl_sync[7];

    // ========================================
    // mode decoding
    adc_ctrl_pkg::level_t range_lvl;
    adc_ctrl_pkg::level_t edge_lvl;
    assign range_lvl = adc_ctrl_pkg::level_of(range_sync);
    assign edge_lvl = adc_ctrl_pkg::level_of(edge_sync);
    wire logic ext_mode = (range_lvl == adc_ctrl_pkg::LVL_MID);

    logic [15:0] config_reg;
    adc_ctrl_pkg::serial_word_t ser_latched;
    logic ser_seen_d;

    wire logic next_range = ext_mode ?
        config_reg[adc_ctrl_pkg::CFG_RANGE_BIT] :
        (range_lvl == adc_ctrl_pkg::LVL_HIGH);
    wire logic next_swing = ext_mode ?
        config_reg[adc_ctrl_pkg::CFG_SWING_BIT] : swing_sync;
    wire logic next_ddr = ext_mode ?
        config_reg[adc_ctrl_pkg::CFG_DDR_BIT] :
        (edge_lvl == adc_ctrl_pkg::LVL_MID);
    wire logic next_edge = ext_mode ?
        config_reg[adc_ctrl_pkg::CFG_EDGE_BIT] :
        (edge_lvl == adc_ctrl_pkg::LVL_HIGH);

    // ========================================
    // serial word arrival
    wire logic ser_arrive = (ser_tog_sync != ser_tog_seen);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ser_tog_seen <= 1'b0;
            ser_seen_d <= 1'b0;
        end else begin
            ser_tog_seen <= ser_tog_sync;
            ser_seen_d <= ser_arrive;
        end
    end

    // the toggle was seen one cycle ago, so the word is long stable
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ser_latched <= '0;
        end else if (ser_seen_d) begin
            ser_latched <= ser_word;
        end
    end

    // ========================================
    // register port
    wire logic bus_cfg_wr = reg_write_in &&
        (reg_addr_in == adc_ctrl_pkg::ADDR_CONFIG);
    wire logic ser_cfg_wr = ser_seen_d && ext_mode &&
        (ser_word.addr == adc_ctrl_pkg::ADDR_CONFIG);
    logic [15:0] status_word;
    logic [15:0] next_rdata;

    always_comb begin
        status_word = '0;
        status_word[adc_ctrl_pkg::ST_EXT_BIT] = extended_mode_out;
        status_word[adc_ctrl_pkg::ST_CAL_BIT] = calibration_running_flag_out;
        status_word[adc_ctrl_pkg::ST_PD_BIT] = power_down_out;
        status_word[adc_ctrl_pkg::ST_DDR_BIT] = ddr_mode_out;
        status_word[adc_ctrl_pkg::ST_RANGE_BIT] = full_scale_range_out;
        case (reg_addr_in)
            adc_ctrl_pkg::ADDR_STATUS: next_rdata = status_word;
            adc_ctrl_pkg::ADDR_CONFIG: next_rdata = config_reg;
            adc_ctrl_pkg::ADDR_SERIAL: next_rdata = ser_latched.data;
            default: next_rdata = 16'h0000;
        endcase
    end

    // the register port wins over a serial write in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            config_reg <= adc_ctrl_pkg::CONFIG_RESET;
        end else if (bus_cfg_wr) begin
            config_reg <= reg_wdata_in;
        end else if (ser_cfg_wr) begin
            config_reg <= ser_word.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= reg_read_in ? next_rdata : 16'h0000;
        end
    end

    // ========================================
    // mode outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            extended_mode_out <= 1'b0;
            full_scale_range_out <= 1'b0;
            output_swing_out <= 1'b1;
            ddr_mode_out <= 1'b0;
            output_edge_out <= 1'b0;
            power_down_out <= 1'b0;
        end else begin
            extended_mode_out <= ext_mode;
            full_scale_range_out <= next_range;
            output_swing_out <= next_swing;
            ddr_mode_out <= next_ddr;
            output_edge_out <= next_edge;
            power_down_out <= pd_sync;
        end
    end

    // ========================================
    // calibration pin filter
    logic [6:0] low_count, high_count;
    logic cal_armed;
    wire logic low_done =
        (low_count == 7'(adc_ctrl_pkg::CAL_PIN_MIN_CYCLES - 1));
    wire logic high_done =
        (high_count == 7'(adc_ctrl_pkg::CAL_PIN_MIN_CYCLES - 1));
    wire logic cal_start = cal_armed && cal_sync && high_done;

    always_ff @(posedge clk_in) begin
        if (rst_in || pd_sync) begin
            low_count <= 7'h00;
            high_count <= 7'h00;
            cal_armed <= 1'b0;
        end else if (!cal_sync) begin
            high_count <= 7'h00;
            low_count <= low_done ? low_count : low_count + 7'h01;
            // a high phase cut short disarms: a fresh low run is needed
            cal_armed <= low_done;
        end else begin
            low_count <= 7'h00;
            high_count <= cal_armed ? high_count + 7'h01 : 7'h00;
            if (cal_start) begin
                cal_armed <= 1'b0;
                high_count <= 7'h00;
            end
        end
    end

    // ========================================
    // calibration sequencer
    adc_ctrl_pkg::cal_state_t cal_state, next_cal_state;
    logic [31:0] cal_count;
    logic [31:0] next_cal_count;
    // delay pin is chip select in extended mode, so the delay goes short
    wire logic long_delay = delay_sync && !ext_mode;
    wire logic [31:0] delay_load = long_delay ?
        32'(CAL_DELAY_LONG - 1) : 32'(CAL_DELAY_SHORT - 1);

    always_comb begin
        next_cal_state = cal_state;
        next_cal_count = cal_count - 32'h0000_0001;
        case (cal_state)
            adc_ctrl_pkg::CAL_WAIT: begin
                if (cal_count == 32'h0000_0000) begin
                    next_cal_state = adc_ctrl_pkg::CAL_RUN;
                    next_cal_count = 32'(CAL_RUN - 1);
                end
            end
            adc_ctrl_pkg::CAL_IDLE: begin
                next_cal_count = cal_count;
                if (cal_start) begin
                    next_cal_state = adc_ctrl_pkg::CAL_RUN;
                    next_cal_count = 32'(CAL_RUN - 1);
                end
            end
            adc_ctrl_pkg::CAL_RUN: begin
                if (cal_count == 32'h0000_0000) begin
                    next_cal_state = adc_ctrl_pkg::CAL_IDLE;
                end
            end
            default: next_cal_state = adc_ctrl_pkg::CAL_IDLE;
        endcase
    end

    // leaving power-down counts as a fresh power-up
    always_ff @(posedge clk_in) begin
        if (rst_in || pd_sync) begin
            cal_state <= adc_ctrl_pkg::CAL_WAIT;
            cal_count <= delay_load;
            calibration_running_flag_out <= 1'b0;
        end else begin
            cal_state <= next_cal_state;
            cal_count <= next_cal_count;
            calibration_running_flag_out <=
                (next_cal_state == adc_ctrl_pkg::CAL_RUN);
        end
    end

    // ========================================
    // output clock reset selection
    logic rst_sel_d;
    wire logic rst_sel_now = config_reg[adc_ctrl_pkg::CFG_RST_SEL_BIT] ?
        rst_diff_sync : rst_single_sync;
    wire logic clk_sync_pulse = rst_sel_now && !rst_sel_d;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rst_sel_d <= 1'b0;
        end else begin
            rst_sel_d <= rst_sel_now;
        end
    end

    // ========================================
    // sample demultiplexer
    logic phase;
    logic div_phase;
    logic [7:0] held0, held1;
    // rise and fall samples of one input clock; the converter samples
    // on both edges, so two words arrive per cycle
    wire logic [7:0] code_rise =
        sample_in.rise ^ adc_ctrl_pkg::OFFSET_FLIP;
    wire logic [7:0] code_fall =
        sample_in.fall ^ adc_ctrl_pkg::OFFSET_FLIP;
    wire logic quiet = pd_sync || clk_sync_pulse;

    always_ff @(posedge clk_in) begin
        if (rst_in || quiet) begin
            phase <= 1'b0;
            held0 <= 8'h00;
            held1 <= 8'h00;
            lane_valid_out <= 1'b0;
        end else begin
            phase <= ~phase;
            lane_valid_out <= phase;
            if (!phase) begin
                held0 <= code_rise;
                held1 <= code_fall;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || pd_sync) begin
            lane_data_out <= '0;
        end else if (phase && !clk_sync_pulse) begin
            lane_data_out <= {code_fall, code_rise, held1, held0};
        end
    end

    // full rate output clock toggles every cycle; DDR halves it
    always_ff @(posedge clk_in) begin
        if (rst_in || quiet) begin
            output_data_clock_out <= 1'b0;
            div_phase <= 1'b0;
        end else begin
            div_phase <= ~div_phase;
            if (!ddr_mode_out || div_phase) begin
                output_data_clock_out <= ~output_data_clock_out;
            end
        end
    end

    // ========================================
    // checks
    property p_ext_mode;
        @(posedge clk_in) disable iff (rst_in)
        range_sync.mid |=> extended_mode_out;
    endproperty
    a_ext_mode: assert property (p_ext_mode)
        else $error("mid range pin did not select extended mode");

    property p_range;
        @(posedge clk_in) disable iff (rst_in)
        (!range_sync.mid && range_sync.high) |=> full_scale_range_out;
    endproperty
    a_range: assert property (p_range)
        else $error("high range pin did not select wide range");

    property p_swing;
        @(posedge clk_in) disable iff (rst_in)
        !ext_mode |=> (output_swing_out == $past(swing_sync));
    endproperty
    a_swing: assert property (p_swing)
        else $error("swing output does not follow the pin");

    property p_ddr;
        @(posedge clk_in) disable iff (rst_in)
        (!ext_mode && edge_sync.mid) |=> ddr_mode_out;
    endproperty
    a_ddr: assert property (p_ddr)
        else $error("mid edge pin did not enable DDR");

    property p_sync_reset;
        @(posedge clk_in) disable iff (rst_in)
        clk_sync_pulse |=> !output_data_clock_out && !lane_valid_out
            ##1 !lane_valid_out;
    endproperty
    a_sync_reset: assert property (p_sync_reset)
        else $error("clock reset pulse did not restart output clock");

    property p_diff_select;
        @(posedge clk_in) disable iff (rst_in)
        (config_reg[adc_ctrl_pkg::CFG_RST_SEL_BIT] && rst_diff_sync &&
            !rst_sel_d) |-> clk_sync_pulse;
    endproperty
    a_diff_select: assert property (p_diff_select)
        else $error("differential reset input ignored");

    property p_power_down;
        @(posedge clk_in) disable iff (rst_in)
        pd_sync |=> power_down_out && !lane_valid_out &&
            !calibration_running_flag_out;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down did not stop the block");

    property p_cal_filter;
        @(posedge clk_in) disable iff (rst_in || pd_sync)
        cal_start |-> cal_sync && $past(cal_sync, 79) &&
            !$past(cal_sync, 80);
    endproperty
    a_cal_filter: assert property (p_cal_filter)
        else $error("calibration started without 80 high cycles");

    property p_cal_run;
        @(posedge clk_in) disable iff (rst_in || pd_sync)
        (cal_state == adc_ctrl_pkg::CAL_IDLE && cal_start) |=>
            calibration_running_flag_out [*2];
    endproperty
    a_cal_run: assert property (p_cal_run)
        else $error("running flag not raised for a calibration");

    property p_flag_state;
        @(posedge clk_in) disable iff (rst_in)
        calibration_running_flag_out == (cal_state == adc_ctrl_pkg::CAL_RUN);
    endproperty
    a_flag_state: assert property (p_flag_state)
        else $error("running flag disagrees with sequencer");

    property p_short_delay;
        @(posedge clk_in) disable iff (rst_in)
        (pd_sync && ext_mode) |=> cal_count == 32'(CAL_DELAY_SHORT - 1);
    endproperty
    a_short_delay: assert property (p_short_delay)
        else $error("extended mode did not force short delay");

    property p_demux;
        @(posedge clk_in) disable iff (rst_in)
        lane_valid_out |=> !lane_valid_out;
    endproperty
    a_demux: assert property (p_demux)
        else $error("lane words faster than a quarter rate");

    property p_offset;
        @(posedge clk_in) disable iff (rst_in)
        lane_valid_out |-> lane_data_out[3] == ($past(sample_in.fall) ^
            adc_ctrl_pkg::OFFSET_FLIP);
    endproperty
    a_offset: assert property (p_offset)
        else $error("lane word not offset binary");

    c_cal_start: cover property (@(posedge clk_in) disable iff (rst_in)
        cal_start ##1 calibration_running_flag_out);
    c_serial_cfg: cover property (@(posedge clk_in) disable iff (rst_in)
        ser_cfg_wr);
    c_lanes: cover property (@(posedge clk_in) disable iff (rst_in)
        lane_valid_out ##2 lane_valid_out);
    c_sync: cover property (@(posedge clk_in) disable iff (rst_in)
        clk_sync_pulse && config_reg[adc_ctrl_pkg::CFG_RST_SEL_BIT]);

endmodule : adc_ctrl

// *** verilog/adc_ctrl_pkg.sv ***
// constants, types and pin decoding for the converter control block
//
// Behaviour
// - floating or mid range pin enters extended control
// - range pin low 600 mV, high 820 mV
// - swing pin clocks serial data in extended mode
// - swing pin high normal, low reduced amplitude
// - edge pin carries serial data in extended mode
// - edge pin picks clock edge, mid gives DDR
// - selected reset pulse resynchronises output data clock
// - config bit 14 selects differential reset input
// - power-down pin high powers down calibration, sample lanes and output data clock
// - 80 low then 80 high cycles start calibration
// - delay pin picks power-up calibration delay
// - extended mode: delay pin is chip select, delay short
// - running flag high exactly while calibrating
// - sample on both input clock edges
// - one-to-four demultiplex onto quarter-rate buses
// - each output word 8-bit offset binary
package adc_ctrl_pkg;

    // ========================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_SERIAL = 4'h2;
    localparam logic [15:0] CONFIG_RESET = 16'h0002;
    localparam int CFG_RANGE_BIT = 0;
    localparam int CFG_SWING_BIT = 1;
    localparam int CFG_EDGE_BIT = 2;
    localparam int CFG_DDR_BIT = 3;
    localparam int CFG_RST_SEL_BIT = 14;
    localparam int ST_EXT_BIT = 0;
    localparam int ST_CAL_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_DDR_BIT = 3;
    localparam int ST_RANGE_BIT = 4;

    // ========================================
    // analog settings and timing
    localparam int RANGE_LOW_MV = 600;
    localparam int RANGE_HIGH_MV = 820;
    localparam int CAL_PIN_MIN_CYCLES = 80;
    localparam int CAL_DELAY_SHORT_CYCLES = 1024;
    localparam int CAL_DELAY_LONG_CYCLES = 65536;
    localparam int CAL_RUN_CYCLES = 2048;

    // ========================================
    // serial frame and sample path
    localparam int SER_ADDR_W = 4;
    localparam int SER_FRAME_BITS = SER_ADDR_W + DATA_W;
    localparam int SAMPLE_W = 8;
    localparam int LANES = 4;
    localparam logic [7:0] OFFSET_FLIP = 8'h80;

    // ========================================
    // types
    typedef enum {LVL_LOW, LVL_HIGH, LVL_MID} level_t;

    typedef enum {CAL_WAIT, CAL_IDLE, CAL_RUN} cal_state_t;

    // pad comparator outputs of one three-level pin
    typedef struct packed {
        logic mid;
        logic high;
    } tri_pin_t;

    typedef struct packed {
        logic [SER_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } serial_word_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] rise;
        logic [SAMPLE_W-1:0] fall;
    } sample_pair_t;

    // mid wins: a floating pin may also trip the high comparator
    function automatic level_t level_of(input tri_pin_t p);
        level_t l;
        l = LVL_LOW;
        if (p.mid) begin
            l = LVL_MID;
        end else if (p.high) begin
            l = LVL_HIGH;
        end
        return l;
    endfunction : level_of

endpackage : adc_ctrl_pkg
